// ===== src/rsc_map.vh
// Purpose: constants for the reset start-up and reset-cause block
// Assumes: 100 MHz clock, AXI4-Lite register access, 32-bit data
// Notes: every offset below is a chosen byte address, each one aligned to a word
// Overview of operation
// - start waits for timers and released pin
// - timers count regardless of reset pin
// - resets other than watchdog update cause flags; watchdog and wake update timeout and powerdown
// - power-on sets flags 00 110x, restarts zero
// - brown-out clears brownout flag, restarts zero
// - pin reset clears ext flag, restarts zero
// - pin reset in sleep: timeout set, powerdown cleared
// - watchdog clears timeout; sleep wake continues next
// - interrupt wake continues next, maybe vectors
// - reset instruction clears its flag, restarts zero
// - stack overflow sets bit 7, restarts zero
// - stack underflow sets bit 6, restarts zero
// - power-on always leaves timeout and powerdown set
// - power-up timer 64 ms when enable bit zero
// - pin enabled by its bit or low-voltage programming
`ifndef RSC_MAP_VH
`define RSC_MAP_VH
`define RSC_OFS_CAUSE 8'h00
`define RSC_OFS_BROWNOUT_CONTROL 8'h04
`define RSC_OFS_STATUS 8'h08
`define RSC_OFS_CFG 8'h0c
`define RSC_OFS_IRQ_STAT 8'h10
`define RSC_OFS_IRQ_MASK 8'h14
`define RSC_OFS_PC 8'h18
`define RSC_BIT_STACK_OVERFLOW_FLAG 7
`define RSC_BIT_STACK_UNDERFLOW_FLAG 6
`define RSC_BIT_EXT 3
`define RSC_BIT_RI 2
`define RSC_BIT_POR 1
`define RSC_BIT_BOR 0
`define RSC_BIT_TO 4
`define RSC_BIT_PD 3
`define RSC_CAUSE_MASK 8'hcf
`define RSC_CFG_RESET 8'h12
`define RSC_BROWNOUT_CONTROL_RESET 8'h80
`define RSC_PC_ZERO 16'h0000
`define RSC_PC_VECTOR 16'h0004
`define RSC_POWERUP_TIMER_MS 64
`define RSC_CLK_KHZ 100000
`define RSC_POWERUP_TIMER_CYCLES (`RSC_POWERUP_TIMER_MS * `RSC_CLK_KHZ)
`define RSC_OST_CYCLES 1024
`endif

// ===== src/rsc_sync.v
// Purpose: two-flop synchroniser for one asynchronous level
// Assumes: destination clock is CLOCK_IN
// Notes: first stage read only by the second stage
`timescale 1ns/1ps
module rsc_sync (
  // clock and reset
  input wire clk_in,
  input wire rst_n_in,
  // level in and out
  input wire d_in,
  output reg q_out
);
  reg meta_q; // first stage, metastable risk
  // two flops in series
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_q <= 1'b0;
      q_out <= 1'b0;
    end else begin
      meta_q <= d_in;
      q_out <= meta_q;
    end
  end
endmodule // rsc_sync

// ===== src/rsc_top.v
// Purpose: start-up gating and reset-cause recording
// Assumes: event inputs are one-cycle pulses on CLOCK_IN; pins are asynchronous
// Notes: RESET_N_IN models the power-on release; brown-out is an asynchronous pin, synchronised and acted on at its rising edge
`timescale 1ns/1ps
`include "rsc_map.vh"
module rsc_top #(
  parameter [31:0] POWERUP_TIMER_CYCLES = `RSC_POWERUP_TIMER_CYCLES, // long count, shorten in sim
  parameter [31:0] OST_CYCLES = `RSC_OST_CYCLES
) (
  // clock and reset
  input wire CLOCK_IN,
  input wire RESET_N_IN,
  // pins from outside
  input wire EXT_RESET_PIN_N_IN,
  input wire BROWNOUT_IN,
  // events from the core, same clock
  input wire WATCHDOG_EVT_IN,
  input wire RESET_INSTR_EVT_IN,
  input wire STACK_OVF_EVT_IN,
  input wire STACK_UNF_EVT_IN,
  input wire IRQ_WAKE_EVT_IN,
  input wire SLEEP_IN,
  input wire GLOBAL_IRQ_ENABLE_IN,
  input wire [15:0] PC_IN,
  // execution control
  output reg RUN_OUT,
  output reg PC_LOAD_OUT,
  output reg [15:0] PC_VALUE_OUT,
  output reg IRQ_VECTOR_OUT,
  output wire IRQ_OUT,
  // axi4-lite write address and data
  input wire [7:0] S_AXI_AWADDR,
  input wire S_AXI_AWVALID,
  output wire S_AXI_AWREADY,
  input wire [31:0] S_AXI_WDATA,
  input wire [3:0] S_AXI_WSTRB,
  input wire S_AXI_WVALID,
  output wire S_AXI_WREADY,
  output reg [1:0] S_AXI_BRESP,
  output reg S_AXI_BVALID,
  input wire S_AXI_BREADY,
  // axi4-lite read
  input wire [7:0] S_AXI_ARADDR,
  input wire S_AXI_ARVALID,
  output wire S_AXI_ARREADY,
  output reg [31:0] S_AXI_RDATA,
  output reg [1:0] S_AXI_RRESP,
  output reg S_AXI_RVALID,
  input wire S_AXI_RREADY
);
  localparam [2:0] ST_WAIT = 3'b001; // timers running or pin held
  localparam [2:0] ST_RUN = 3'b010; // executing
  localparam [2:0] ST_HOLD = 3'b100; // held in reset by the pin
  wire pin_n_s; // synchronised reset pin
  wire bor_s; // synchronised brown-out
  reg bor_d1_q; // brown-out edge detect
  reg [2:0] st_q;
  reg [31:0] powerup_timer_q; // power-up timer down count
  reg [31:0] ost_q; // oscillator start-up down count
  reg [7:0] cause_q; // reset-cause flags
  reg to_q; // timeout flag, active low
  reg pd_q; // powerdown flag, active low
  reg sbor_q; // software brown-out enable
  reg [7:0] cfg_q; // bit0 timer en_n, 1 pin en, 2 lvp, 3 stack reset en, 4 osc needs ost
  wire [3:0] ist_q; // sticky events: 0 reset,1 wake,2 brown-out,3 stack
  reg [31:0] rd_word; // decoded read value, registered on the read channel
  localparam [7:0] CFG_RST = `RSC_CFG_RESET; // power-on configuration
  localparam [7:0] BROWNOUT_CONTROL_RST = `RSC_BROWNOUT_CONTROL_RESET; // power-on brown-out control
  reg [3:0] imask_q;
  reg [15:0] pc_q; // last restart address
  reg aw_q, w_q; // captured write halves
  reg [7:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  wire pin_en = cfg_q[1] | cfg_q[2];
  wire pin_low = pin_en & ~pin_n_s;
  wire bor_evt = bor_s & ~bor_d1_q;
  wire stk_evt = cfg_q[3] & (STACK_OVF_EVT_IN | STACK_UNF_EVT_IN);
  wire timers_done = (powerup_timer_q == 32'h0000_0000) && (ost_q == 32'h0000_0000);
  wire wr_go = aw_q & w_q & ~S_AXI_BVALID;
  wire running = (st_q == ST_RUN);
  wire rst_evt = running & (WATCHDOG_EVT_IN & ~SLEEP_IN | RESET_INSTR_EVT_IN | stk_evt);
  wire wake_evt = running & SLEEP_IN & (WATCHDOG_EVT_IN | IRQ_WAKE_EVT_IN);
  wire pin_evt = running & pin_low;
  wire [3:0] ev = {stk_evt & running, bor_evt, wake_evt, rst_evt | pin_evt};
  // write-one-to-clear strobe for the sticky event bits
  wire ist_wr = wr_go & (awaddr_q == `RSC_OFS_IRQ_STAT) & wstrb_q[0];
  wire bor_ready = ~bor_s; // detector active while supply is good
  // synchronisers for the pins
  rsc_sync u_pin (.clk_in(CLOCK_IN), .rst_n_in(RESET_N_IN), .d_in(EXT_RESET_PIN_N_IN),
    .q_out(pin_n_s));
  rsc_sync u_bor (.clk_in(CLOCK_IN), .rst_n_in(RESET_N_IN), .d_in(BROWNOUT_IN),
    .q_out(bor_s));
  assign S_AXI_AWREADY = ~aw_q;
  assign S_AXI_WREADY = ~w_q;
  assign S_AXI_ARREADY = ~S_AXI_RVALID;
  assign IRQ_OUT = |(ist_q & imask_q);

  // sticky event bits, one flop each
  // an event in the cycle of a software clear wins, so no event is lost
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_ist
      reg bit_q; // sticky copy of one event
      always @(posedge CLOCK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN)
          bit_q <= (gi == 0) ? 1'b1 : 1'b0; // power-on counts as a reset
        else if (ev[gi])
          bit_q <= 1'b1;
        else if (ist_wr && wdata_q[gi])
          bit_q <= 1'b0;
      end
      assign ist_q[gi] = bit_q;
    end
  endgenerate

  // software configuration, brown-out control and interrupt mask
  // timer configuration only takes effect at the next brown-out restart
  always @(posedge CLOCK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      cfg_q <= `RSC_CFG_RESET;
      sbor_q <= BROWNOUT_CONTROL_RST[7]; // enabled at power-on
      imask_q <= 4'h0;
    end else if (wr_go && wstrb_q[0]) begin
      case (awaddr_q)
        `RSC_OFS_CFG: cfg_q <= wdata_q[7:0];
        `RSC_OFS_BROWNOUT_CONTROL: sbor_q <= wdata_q[7];
        `RSC_OFS_IRQ_MASK: imask_q <= wdata_q[3:0];
        default: imask_q <= imask_q; // other offsets live elsewhere
      endcase
    end
  end

  // read decode; unmapped offsets read as zero
  always @* begin
    rd_word = 32'h0000_0000;
    case (S_AXI_ARADDR)
      `RSC_OFS_CAUSE: rd_word = {24'h00_0000, cause_q & `RSC_CAUSE_MASK};
      `RSC_OFS_BROWNOUT_CONTROL: rd_word = {24'h00_0000, sbor_q, 6'h00, bor_ready};
      `RSC_OFS_STATUS: rd_word = {27'h000_0000, to_q, pd_q, 3'h0};
      `RSC_OFS_CFG: rd_word = {24'h00_0000, cfg_q};
      `RSC_OFS_IRQ_STAT: rd_word = {28'h000_0000, ist_q};
      `RSC_OFS_IRQ_MASK: rd_word = {28'h000_0000, imask_q};
      `RSC_OFS_PC: rd_word = {16'h0000, pc_q};
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // start-up sequencer, timers and flags
  always @(posedge CLOCK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      st_q <= ST_WAIT;
      powerup_timer_q <= CFG_RST[0] ? 32'h0000_0000 : POWERUP_TIMER_CYCLES;
      ost_q <= CFG_RST[4] ? OST_CYCLES : 32'h0000_0000;
      bor_d1_q <= 1'b0;
      cause_q <= 8'h0c;
      to_q <= 1'b1;
      pd_q <= 1'b1;
      RUN_OUT <= 1'b0;
      PC_LOAD_OUT <= 1'b0;
      PC_VALUE_OUT <= `RSC_PC_ZERO;
      IRQ_VECTOR_OUT <= 1'b0;
      pc_q <= `RSC_PC_ZERO;
    end else begin
      bor_d1_q <= bor_s;
      PC_LOAD_OUT <= 1'b0;
      IRQ_VECTOR_OUT <= 1'b0;
      // software writes; a hardware update below wins in the same cycle
      if (wr_go && awaddr_q == `RSC_OFS_CAUSE && wstrb_q[0])
        cause_q <= wdata_q[7:0] & `RSC_CAUSE_MASK;
      if (bor_evt) begin
        cause_q[`RSC_BIT_BOR] <= 1'b0;
        cause_q[`RSC_BIT_STACK_OVERFLOW_FLAG] <= 1'b0;
        cause_q[`RSC_BIT_STACK_UNDERFLOW_FLAG] <= 1'b0;
        cause_q[`RSC_BIT_EXT] <= 1'b1;
        cause_q[`RSC_BIT_RI] <= 1'b1;
        to_q <= 1'b1;
        pd_q <= 1'b1;
        st_q <= ST_WAIT;
        RUN_OUT <= 1'b0;
        powerup_timer_q <= cfg_q[0] ? 32'h0000_0000 : POWERUP_TIMER_CYCLES;
        ost_q <= cfg_q[4] ? OST_CYCLES : 32'h0000_0000;
        pc_q <= `RSC_PC_ZERO;
      end else begin
        case (st_q)
          ST_WAIT: begin
            // timers were loaded by reset or by the brown-out branch
            if (powerup_timer_q != 32'h0000_0000) powerup_timer_q <= powerup_timer_q - 32'h0000_0001;
            if (ost_q != 32'h0000_0000) ost_q <= ost_q - 32'h0000_0001;
            if (timers_done && !pin_low) begin
              st_q <= ST_RUN;
              RUN_OUT <= 1'b1;
              PC_LOAD_OUT <= 1'b1;
              PC_VALUE_OUT <= `RSC_PC_ZERO;
            end
          end
          ST_RUN: begin
            if (pin_low) begin
              cause_q[`RSC_BIT_EXT] <= 1'b0;
              if (SLEEP_IN) begin
                to_q <= 1'b1;
                pd_q <= 1'b0;
              end
              st_q <= ST_HOLD;
              RUN_OUT <= 1'b0;
            end else if (stk_evt) begin
              if (STACK_OVF_EVT_IN) cause_q[`RSC_BIT_STACK_OVERFLOW_FLAG] <= 1'b1;
              if (STACK_UNF_EVT_IN) cause_q[`RSC_BIT_STACK_UNDERFLOW_FLAG] <= 1'b1;
              PC_LOAD_OUT <= 1'b1;
              PC_VALUE_OUT <= `RSC_PC_ZERO;
            end else if (RESET_INSTR_EVT_IN) begin
              cause_q[`RSC_BIT_RI] <= 1'b0;
              PC_LOAD_OUT <= 1'b1;
              PC_VALUE_OUT <= `RSC_PC_ZERO;
            end else if (WATCHDOG_EVT_IN) begin
              to_q <= 1'b0;
              PC_LOAD_OUT <= 1'b1;
              if (SLEEP_IN) begin
                pd_q <= 1'b0;
                PC_VALUE_OUT <= PC_IN + 16'h0001;
              end else
                PC_VALUE_OUT <= `RSC_PC_ZERO;
            end else if (IRQ_WAKE_EVT_IN && SLEEP_IN) begin
              to_q <= 1'b1;
              pd_q <= 1'b0;
              PC_LOAD_OUT <= 1'b1;
              PC_VALUE_OUT <= PC_IN + 16'h0001;
              IRQ_VECTOR_OUT <= GLOBAL_IRQ_ENABLE_IN;
            end
          end
          ST_HOLD: begin
            if (!pin_low) begin
              st_q <= ST_RUN;
              RUN_OUT <= 1'b1;
              PC_LOAD_OUT <= 1'b1;
              PC_VALUE_OUT <= `RSC_PC_ZERO;
            end
          end
          default: st_q <= ST_WAIT;
        endcase
      end
      if (PC_LOAD_OUT) pc_q <= PC_VALUE_OUT;
    end
  end

  // write channel: address and data are taken in either order
  // the response is raised once both halves are in; a new address may
  // be taken while the response waits, but is not acted on until it goes
  always @(posedge CLOCK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= 2'b00;
    end else begin
      if (S_AXI_AWVALID && !aw_q) begin // address taken
        aw_q <= 1'b1;
        awaddr_q <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && !w_q) begin // data taken
        w_q <= 1'b1;
        wdata_q <= S_AXI_WDATA;
        wstrb_q <= S_AXI_WSTRB;
      end
      if (wr_go) begin // both halves in, answer
        aw_q <= 1'b0;
        w_q <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= 2'b00; // every write is accepted
      end else if (S_AXI_BREADY) begin // response taken
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // read channel: one read in flight, data registered with valid
  // address ready drops while data wait, which keeps one read at a time
  always @(posedge CLOCK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= 2'b00;
    end else if (S_AXI_ARVALID && !S_AXI_RVALID) begin // address taken
      S_AXI_RVALID <= 1'b1;
      S_AXI_RRESP <= 2'b00;
      S_AXI_RDATA <= rd_word;
    end else if (S_AXI_RREADY) begin // data taken
      S_AXI_RVALID <= 1'b0;
    end
  end
endmodule // rsc_top


// ===== tb/rsc_top_assertions.sv
// Purpose: port checker for the start-up and reset-cause block
// Assumes: pin reset enabled by default configuration
// Notes: bound to every rsc_top instance
`timescale 1ns/1ps
module rsc_top_assertions #(
  parameter [31:0] POWERUP_TIMER_CYCLES = 32'd200,
  parameter [31:0] OST_CYCLES = 32'd50
) (
  // clock, reset, sources
  input wire CLOCK_IN,
  input wire RESET_N_IN,
  input wire EXT_RESET_PIN_N_IN,
  input wire WATCHDOG_EVT_IN,
  input wire RESET_INSTR_EVT_IN,
  input wire IRQ_WAKE_EVT_IN,
  input wire SLEEP_IN,
  input wire GLOBAL_IRQ_ENABLE_IN,
  input wire [15:0] PC_IN,
  // execution and read bus
  input wire RUN_OUT,
  input wire PC_LOAD_OUT,
  input wire [15:0] PC_VALUE_OUT,
  input wire [7:0] S_AXI_ARADDR,
  input wire S_AXI_ARVALID,
  input wire S_AXI_ARREADY,
  input wire [31:0] S_AXI_RDATA,
  input wire S_AXI_RVALID
);
  default clocking @(posedge CLOCK_IN); endclocking
  default disable iff (!RESET_N_IN);
  logic [31:0] age_q; // cycles since release, saturating
  logic first_q; // still in the first start-up
  logic [7:0] ra_q; // last accepted read address
  // helper state; saturation keeps long runs from wrapping
  always @(posedge CLOCK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      age_q <= 32'h0;
      first_q <= 1'b1;
      ra_q <= 8'h00;
    end else begin
      if (age_q != 32'hffffffff) age_q <= age_q + 32'h1;
      if (RUN_OUT) first_q <= 1'b0;
      if (S_AXI_ARVALID && S_AXI_ARREADY) ra_q <= S_AXI_ARADDR;
    end
  end
  sequence restart_zero;
    ##[0:16] (PC_LOAD_OUT && PC_VALUE_OUT == 16'h0000);
  endsequence
  sequence resume_next;
    ##[0:16] (PC_LOAD_OUT && PC_VALUE_OUT == PC_IN + 16'h0001);
  endsequence
  a_start_waits_osc: assert property ($rose(RUN_OUT) && first_q |-> age_q >= OST_CYCLES)
    else $error("core started before oscillator wait");
  a_pin_holds_core: assert property (!EXT_RESET_PIN_N_IN [*4] |-> !RUN_OUT)
    else $error("core runs while pin held low");
  a_pin_release_runs: assert property (first_q && $rose(EXT_RESET_PIN_N_IN)
      && age_q > POWERUP_TIMER_CYCLES + OST_CYCLES |-> ##[1:8] RUN_OUT)
    else $error("late start after pin release");
  a_ri_restart_zero: assert property (RESET_INSTR_EVT_IN |-> restart_zero)
    else $error("reset instruction did not restart at zero");
  a_wdt_restart_zero: assert property (WATCHDOG_EVT_IN && !SLEEP_IN |-> restart_zero)
    else $error("watchdog did not restart at zero");
  a_wdt_sleep_next: assert property (WATCHDOG_EVT_IN && SLEEP_IN |-> resume_next)
    else $error("watchdog wake did not resume next");
  a_irq_wake_next: assert property (IRQ_WAKE_EVT_IN && SLEEP_IN && !GLOBAL_IRQ_ENABLE_IN
      |-> resume_next)
    else $error("interrupt wake did not resume next");
  a_cause_gap_zero: assert property (S_AXI_RVALID && ra_q == 8'h00
      |-> S_AXI_RDATA[5:4] == 2'b00)
    else $error("cause bits five and four not zero");
endmodule // rsc_top_assertions
bind rsc_top rsc_top_assertions #(.POWERUP_TIMER_CYCLES(POWERUP_TIMER_CYCLES), .OST_CYCLES(OST_CYCLES)) u_chk (.*);

// ===== tb/rsc_src.sv
// Purpose: model of the reset pin and on-chip reset sources
// Assumes: events are one-cycle pulses on the block clock
// Notes: pin idles high, as its pull-up would leave it
`timescale 1ns/1ps
module rsc_src (
  // clock
  input wire clk_in,
  // pin and events: wdt, ri, ovf, unf, irq wake
  output logic pin_n_out,
  output logic [4:0] evt_out
);
  initial begin
    pin_n_out = 1'b1;
    evt_out = 5'h00;
  end
  // one pulse, launched just after an edge
  task automatic pulse(input logic [4:0] which);
    @(posedge clk_in);
    evt_out <= which;
    @(posedge clk_in);
    evt_out <= 5'h00;
  endtask
  // pin pulled low for a count of cycles, then left to the pull-up
  task automatic hold_pin(input int cycles);
    @(posedge clk_in);
    pin_n_out <= 1'b0;
    repeat (cycles) @(posedge clk_in);
    pin_n_out <= 1'b1;
  endtask
endmodule // rsc_src

// ===== tb/rsc_top_test.sv
// Purpose: self-checking bench for the reset-cause block
// Assumes: default configuration, timers shortened
// Notes: status flags are read back through the register bus
`timescale 1ns/1ps
module rsc_top_test;
  logic clk = 0, rst_n = 0, sl = 0, awv = 0, wv = 0, bi = 0, arv = 0, ri = 0;
  logic bo = 0, global_irq_enable = 0, vseen = 0;
  logic [7:0] aw = 0, ar = 0;
  logic [31:0] wd = 0, d, rdat;
  wire pin_n, run, irq, awr, wr_r, bv, arr, rv, ivec;
  wire [4:0] ev;
  int miscompares = 0, n_checks = 0;
  always #5 clk = ~clk;
  rsc_src u_src (.clk_in(clk), .pin_n_out(pin_n), .evt_out(ev));
  rsc_top #(.POWERUP_TIMER_CYCLES(32'd200), .OST_CYCLES(32'd50)) u_dut (.CLOCK_IN(clk),
    .RESET_N_IN(rst_n), .EXT_RESET_PIN_N_IN(pin_n), .BROWNOUT_IN(bo),
    .WATCHDOG_EVT_IN(ev[0]), .RESET_INSTR_EVT_IN(ev[1]), .STACK_OVF_EVT_IN(ev[2]),
    .STACK_UNF_EVT_IN(ev[3]), .IRQ_WAKE_EVT_IN(ev[4]), .SLEEP_IN(sl),
    .GLOBAL_IRQ_ENABLE_IN(global_irq_enable), .PC_IN(16'h0123), .RUN_OUT(run), .PC_LOAD_OUT(),
    .PC_VALUE_OUT(), .IRQ_VECTOR_OUT(ivec), .IRQ_OUT(irq), .S_AXI_AWADDR(aw),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf),
    .S_AXI_WVALID(wv), .S_AXI_WREADY(wr_r), .S_AXI_BRESP(), .S_AXI_BVALID(bv),
    .S_AXI_BREADY(bi), .S_AXI_ARADDR(ar), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
    .S_AXI_RDATA(rdat), .S_AXI_RRESP(), .S_AXI_RVALID(rv), .S_AXI_RREADY(ri));
  // write: address and data offered together, each dropped when taken
  // ready and valid are sampled at the falling edge, as they stand at the next rise
  always @(posedge clk) if (ivec) vseen <= 1;
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic ta, tw, tb;
    @(posedge clk);
    aw <= a;
    wd <= v;
    awv <= 1;
    wv <= 1;
    bi <= 1;
    do begin
      @(negedge clk);
      ta = awr;
      tw = wr_r;
      tb = bv;
      @(posedge clk);
      if (ta) awv <= 0;
      if (tw) wv <= 0;
    end while (!tb);
    bi <= 0;
  endtask
  // read: rready held until the data arrive
  task automatic rd(input logic [7:0] a);
    logic ta, tb;
    @(posedge clk);
    ar <= a;
    arv <= 1;
    ri <= 1;
    do begin
      @(negedge clk);
      ta = arr;
      tb = rv;
      if (rv) d = rdat;
      @(posedge clk);
      if (ta) arv <= 0;
    end while (!tb);
    ri <= 0;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // bounded wait for the core to run again
  task automatic wait_run;
    repeat (20) @(posedge clk);
    for (int n = 0; n < 1000 && run !== 1'b1; n++) @(posedge clk);
  endtask
  // rearm flags, fire one source, then read both flag registers
  task automatic t_cause(input logic [4:0] e, input int pin, input logic s,
      input logic [7:0] ec, input logic [1:0] es);
    wr(8'h00, 32'h3f);
    rd(8'h00);
    chk("rearm", 32'h0f, d);
    sl <= s;
    if (e != 0) u_src.pulse(e);
    if (pin > 0) u_src.hold_pin(pin);
    wait_run();
    sl <= 0;
    rd(8'h00);
    chk("cause", {24'h0, ec}, d);
    rd(8'h08);
    chk("timeout powerdown", {30'h0, es}, {30'h0, d[4:3]});
    $display("cause test %h done", ec);
  endtask
  // brown-out: core halts, timers rerun, then flags are read
  task automatic t_brownout;
    wr(8'h00, 32'h3f);
    @(posedge clk);
    bo <= 1;
    @(posedge clk);
    bo <= 0;
    repeat (8) @(posedge clk);
    chk("halted by brown-out", 32'h0, {31'h0, run});
    repeat (100) @(posedge clk);
    chk("start waits for timer", 32'h0, {31'h0, run});
    wait_run();
    rd(8'h00);
    chk("brown-out cause", 32'h0e, d);
    rd(8'h08);
    chk("brown-out flags", 32'h3, {30'h0, d[4:3]});
    $display("brown-out test done");
  endtask
  task automatic close_out;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    close_out();
  end
  initial begin
    fork u_src.hold_pin(400); join_none
    repeat (8) @(posedge clk);
    rst_n <= 1;
    wait_run();
    chk("run after pin", 32'h1, {31'h0, run});
    rd(8'h00);
    chk("power-on cause", 32'h0c, d & 32'hfe);
    rd(8'h08);
    chk("power-on flags", 32'h3, {30'h0, d[4:3]});
    $display("start-up test done");
    t_cause(5'h02, 0, 0, 8'h0b, 2'b11);
    t_cause(5'h00, 20, 0, 8'h07, 2'b11);
    t_cause(5'h01, 0, 0, 8'h0f, 2'b01);
    t_cause(5'h10, 0, 1, 8'h0f, 2'b10);
    t_cause(5'h01, 0, 1, 8'h0f, 2'b00);
    t_cause(5'h00, 20, 1, 8'h07, 2'b10);
    t_brownout();
    wr(8'h0c, 32'h1a);
    t_cause(5'h04, 0, 0, 8'h8f, 2'b11);
    t_cause(5'h08, 0, 0, 8'h4f, 2'b11);
    global_irq_enable <= 1;
    t_cause(5'h10, 0, 1, 8'h0f, 2'b10);
    chk("vector taken", 32'h1, {31'h0, vseen});
    global_irq_enable <= 0;
    wr(8'h14, 32'hffffffff);
    chk("irq line high", 32'h1, {31'h0, irq});
    wr(8'h10, 32'hffffffff);
    rd(8'h10);
    chk("irq status cleared", 32'h0, d);
    chk("irq line low", 32'h0, {31'h0, irq});
    rd(8'h40);
    chk("unmapped read", 32'h0, d);
    $display("interrupt and unmapped test done");
    close_out();
  end
endmodule // rsc_top_test
